// ---- design/tfr_axis_fmt.sv ----
`timescale 1ns/100ps

module tfr_axis_fmt (
    // element values
    input wire logic signed [11:0] inner,
    input wire logic signed [11:0] outer_a,
    input wire logic signed [11:0] outer_b,
    // scheme
    input wire logic summed,
    // result
    output logic signed [11:0] value
);

    logic signed [12:0] sum;

    assign sum = 13'(outer_a) + 13'(outer_b);

    // the pair sum saturates instead of wrapping, so a strong field
    // never flips sign in the result
    always_comb begin
        if (!summed) begin
            value = inner;
        end else if (sum > 13'sh07FF) begin
            value = 12'sh7FF;
        end else if (sum < -13'sh0800) begin
            value = -12'sh800;
        end else begin
            value = sum[11:0];
        end
    end

endmodule : tfr_axis_fmt

// ---- design/tfr_readout_top.sv ----
// Behaviour
// - each axis gives 12 bits split over upper and lower result words
// - upper bits above lower bits form a signed two's complement value
// - one continuous read of both result words returns one sample
// - a 12-bit temperature code is split over the same result words
// - temperature valid within 8 ms of power-on, refreshed every 8 ms
// - in duty-cycled mode temperature refreshes once per ten cycles
// - mode field selects active, sleep or duty-cycled operation
// - sleep keeps the access port alive but freezes all results
// - leaving sleep costs the same delay as power-on
// - duty-cycled mode alternates measuring and inactive phases
// - inactive field picks 0.5 to 1000 ms inactive duration
// - active phase length follows bandwidth and enabled channel count
// - bandwidth field: codes 0-2 filtered, 4-6 bypassed, 3 and 7 undefined
// - update period depends on bandwidth code and channel count
// - configuration bits 6, 7, 8 enable X, Y, Z channels
// - scheme field selects inner elements or summed outer elements
// - summed scheme: X east plus west, Y north plus south, Z unchanged
// - interrupt when enabled axis value reaches its threshold
// - fixed bit positions of axis upper and lower parts
// - fresh-sample flag set on new sample, cleared by reading
// - lower word reports the scheme that made the current sample
`timescale 1ns/100ps
`include "tfr_cfg.svh"

module tfr_readout_top #(
    parameter int unsigned TEMP_CYCLES =
        `TFR_TEMP_PERIOD_US * `TFR_CLK_MHZ,
    parameter int unsigned POD_CYCLES = `TFR_POD_US * `TFR_CLK_MHZ,
    parameter int unsigned INACT_BASE_CYCLES =
        `TFR_INACT_BASE_US * `TFR_CLK_MHZ
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register access port
    input wire logic [7:0] acc_addr,
    input wire logic acc_wr,
    input wire logic acc_rd,
    input wire logic [31:0] acc_wdata,
    output logic [31:0] acc_rdata,
    // sensing elements and temperature, from the converter
    input tfr_pkg::tfr_elems_type elems,
    // threshold compare
    input tfr_pkg::tfr_axes_type int_threshold,
    input wire logic [2:0] int_axis_en,
    output logic int_event
);

    ////////////////////////////////////////////////////////////////////
    // parameter check

    if (TEMP_CYCLES < 1 || TEMP_CYCLES > `TFR_TIMER_MAX ||
        POD_CYCLES < 1 || POD_CYCLES > `TFR_TIMER_MAX ||
        INACT_BASE_CYCLES < 1 ||
        INACT_BASE_CYCLES * 2000 > `TFR_TIMER_MAX) begin : g_bad_param
        $error("tfr_readout_top: timing parameter out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // declarations

    tfr_pkg::tfr_top_state_type q;
    tfr_pkg::tfr_top_state_type d;
    tfr_pkg::tfr_elems_type elems_s;
    tfr_pkg::tfr_axes_type cand;
    tfr_pkg::tfr_mode_type mode;

    logic [2:0] chen;
    logic [2:0] bw;
    logic [1:0] nch;
    logic [1:0] row_idx;
    logic [29:0] upd_row;
    logic [9:0] upd_us;
    logic [23:0] upd_cycles;
    logic [87:0] inact_mult;
    logic [10:0] mult;
    logic [23:0] inact_cycles;
    logic summed;
    logic meas_ok;
    logic sleep_req;
    logic duty;
    logic sample_now;
    logic temp_now;
    logic [2:0] hit;
    logic [31:0] hi_word;
    logic [31:0] lo_word;

    ////////////////////////////////////////////////////////////////////
    // converter inputs cross into the core clock

    tfr_sync #(
        .WIDTH($bits(tfr_pkg::tfr_elems_type))
    ) u_elem_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(elems),
        .sync_out(elems_s)
    );

    ////////////////////////////////////////////////////////////////////
    // configuration decode

    // reserved mode code 3 runs as active: an unknown setting should
    // keep data flowing rather than stall the host
    assign mode = tfr_pkg::tfr_mode_type'(q.power[`TFR_F_MODE]);
    assign sleep_req = (mode == tfr_pkg::MODE_SLEEP);
    assign duty = (mode == tfr_pkg::MODE_DUTY);
    assign chen = q.sense_cfg[`TFR_F_CHEN];
    assign bw = q.sense_cfg[`TFR_F_BW];
    // reserved scheme code 1 falls back to the inner elements
    assign summed = (q.sense_cfg[`TFR_F_HALL] == `TFR_HALL_SUMMED);

    assign nch = {1'b0, chen[0]} + {1'b0, chen[1]} + {1'b0, chen[2]};

    // undefined bandwidth codes and no enabled channel give no sample
    assign meas_ok = (bw[1:0] != 2'h3) && (nch != 2'h0);

    // update period table
    always_comb begin
        unique case (bw)
            3'h0: upd_row = `TFR_UPD_US_BW0;
            3'h1: upd_row = `TFR_UPD_US_BW1;
            3'h2: upd_row = `TFR_UPD_US_BW2;
            3'h4: upd_row = `TFR_UPD_US_BW4;
            3'h5: upd_row = `TFR_UPD_US_BW5;
            3'h6: upd_row = `TFR_UPD_US_BW6;
            default: upd_row = `TFR_UPD_US_BW0;
        endcase
    end

    assign row_idx = (nch == 2'h0) ? 2'h0 : nch - 2'h1;
    assign upd_us = upd_row[10 * row_idx +: 10];
    // active phase = one update period for this setting
    assign upd_cycles = 24'(upd_us * `TFR_CLK_MHZ);

    assign inact_mult = `TFR_INACT_MULT;
    assign mult = inact_mult[11 * q.power[`TFR_F_INACT] +: 11];
    assign inact_cycles = 24'(INACT_BASE_CYCLES * mult);

    ////////////////////////////////////////////////////////////////////
    // axis formatting

    tfr_axis_fmt u_fmt_x (
        .inner(elems_s.x_inner),
        .outer_a(elems_s.x_east),
        .outer_b(elems_s.x_west),
        .summed(summed),
        .value(cand.x)
    );

    tfr_axis_fmt u_fmt_y (
        .inner(elems_s.y_inner),
        .outer_a(elems_s.y_north),
        .outer_b(elems_s.y_south),
        .summed(summed),
        .value(cand.y)
    );

    // z has no outer pair: same data in either scheme
    tfr_axis_fmt u_fmt_z (
        .inner(elems_s.z_inner),
        .outer_a(12'sh000),
        .outer_b(12'sh000),
        .summed(1'b0),
        .value(cand.z)
    );

    ////////////////////////////////////////////////////////////////////
    // result words

    assign hit[0] = int_axis_en[0] && (q.axes.x >= int_threshold.x);
    assign hit[1] = int_axis_en[1] && (q.axes.y >= int_threshold.y);
    assign hit[2] = int_axis_en[2] && (q.axes.z >= int_threshold.z);

    // bit 6 mirrors the event pin; all axis values stay two's complement
    // so the host can sign-extend the concatenated halves directly
    assign hi_word = {
        q.axes.x[11:4],
        q.axes.y[11:4],
        q.axes.z[11:4],
        q.new_flag,
        q.int_flag,
        q.temp[11:6]
    };

    // bit 20 (eeprom write busy) is always clear: no eeprom here
    assign lo_word = {
        12'h000,
        q.axes.x[3:0],
        q.axes.y[3:0],
        q.axes.z[3:0],
        q.hall_stat,
        q.temp[5:0]
    };

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        sample_now = 1'b0;
        temp_now = 1'b0;

        // sleep wins in every state, so a sleep request never waits for
        // a long inactive phase to run out
        unique case (q.state)
            tfr_pkg::ST_WAKE: begin
                if (sleep_req) begin
                    d.state = tfr_pkg::ST_SLEEP;
                end else if (q.timer == 24'h000000) begin
                    d.state = tfr_pkg::ST_MEASURE;
                    d.timer = upd_cycles;
                    d.temp_timer = 24'(TEMP_CYCLES);
                    d.duty_cnt = 4'h0;
                    temp_now = 1'b1;
                end else begin
                    d.timer = q.timer - 24'h000001;
                end
            end
            tfr_pkg::ST_MEASURE: begin
                if (sleep_req) begin
                    d.state = tfr_pkg::ST_SLEEP;
                end else begin
                    if (q.timer == 24'h000000) begin
                        sample_now = meas_ok;
                        if (duty) begin
                            d.state = tfr_pkg::ST_INACTIVE;
                            d.timer = inact_cycles;
                            // sparse temperature refresh saves power
                            if (q.duty_cnt == `TFR_TEMP_EVERY - 4'h1) begin
                                temp_now = 1'b1;
                                d.duty_cnt = 4'h0;
                            end else begin
                                d.duty_cnt = q.duty_cnt + 4'h1;
                            end
                        end else begin
                            d.timer = upd_cycles;
                        end
                    end else begin
                        d.timer = q.timer - 24'h000001;
                    end
                    // free-running refresh only while fully active
                    if (!duty) begin
                        if (q.temp_timer == 24'h000000) begin
                            temp_now = 1'b1;
                            d.temp_timer = 24'(TEMP_CYCLES);
                        end else begin
                            d.temp_timer = q.temp_timer - 24'h000001;
                        end
                    end
                end
            end
            tfr_pkg::ST_INACTIVE: begin
                if (sleep_req) begin
                    d.state = tfr_pkg::ST_SLEEP;
                end else if (!duty || q.timer == 24'h000000) begin
                    d.state = tfr_pkg::ST_MEASURE;
                    d.timer = upd_cycles;
                end else begin
                    d.timer = q.timer - 24'h000001;
                end
            end
            tfr_pkg::ST_SLEEP: begin
                // results frozen; the access port below still runs
                if (!sleep_req) begin
                    d.state = tfr_pkg::ST_WAKE;
                    d.timer = 24'(POD_CYCLES);
                end
            end
        endcase

        // a mode write lands at the same edge as any state change, so the
        // new mode steers the machine from the following cycle
        // register writes; result words are read only
        if (acc_wr && acc_addr == `TFR_OFS_SENSE) begin
            d.sense_cfg = acc_wdata;
        end
        if (acc_wr && acc_addr == `TFR_OFS_POWER) begin
            d.power = acc_wdata[`TFR_F_POWER];
        end

        // an upper-word read freezes the lower word, so the pair stays one
        // sample even when a fresh sample lands between the two reads
        // register reads
        if (acc_rd) begin
            case (acc_addr)
                `TFR_OFS_SENSE: d.rdata = q.sense_cfg;
                `TFR_OFS_POWER: d.rdata = {25'h0000000, q.power};
                `TFR_OFS_RES_HI: begin
                    d.rdata = hi_word;
                    // freeze the lower half of this very sample
                    d.lo_snap = lo_word;
                    d.snap_valid = 1'b1;
                    d.new_flag = 1'b0;
                end
                `TFR_OFS_RES_LO: begin
                    d.rdata = q.snap_valid ? q.lo_snap : lo_word;
                    d.snap_valid = 1'b0;
                end
                default: d.rdata = 32'h00000000;
            endcase
        end

        // a new sample after the clear wins over it
        if (sample_now) begin
            d.axes.x = chen[0] ? cand.x : 12'sh000;
            d.axes.y = chen[1] ? cand.y : 12'sh000;
            d.axes.z = chen[2] ? cand.z : 12'sh000;
            d.hall_stat = summed ? `TFR_HALL_SUMMED : `TFR_HALL_INNER;
            d.new_flag = 1'b1;
        end
        if (temp_now) begin
            d.temp = elems_s.temp;
        end

        // unlatched: the event follows the stored sample and drops with it
        d.int_flag = |hit;
    end

    ////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge core_clk) begin
        // only the wake timer and the sensing configuration leave reset non-zero
        if (rst) begin
            q <= '0;
            q.timer <= 24'(POD_CYCLES);
            q.sense_cfg <= `TFR_SENSE_RESET;
            q.power <= `TFR_POWER_RESET;
        end else begin
            q <= d;
        end
    end

    // both outputs come straight from flip-flops
    assign acc_rdata = q.rdata;
    assign int_event = q.int_flag;

endmodule : tfr_readout_top

// ---- design/tfr_sync.sv ----
`timescale 1ns/100ps

module tfr_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] last;
        logic [WIDTH-1:0] held;
    } tfr_sync_state_type;

    tfr_sync_state_type q;
    tfr_sync_state_type d;

    if (WIDTH < 1) begin : g_bad_width
        $error("tfr_sync: width must be at least one");
    end

    // the first stage feeds only the second stage; a word is passed on
    // only after two equal synchronised samples, so a capture torn by a
    // change between bits never reaches the core (costs two cycles)
    always_comb begin
        d.meta = async_in;
        d.stable = q.meta;
        d.last = q.stable;
        d.held = (q.stable == q.last) ? q.stable : q.held;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_out = q.held;

endmodule : tfr_sync

// ---- inc/tfr_cfg.svh ----
`ifndef TFR_CFG_SVH
`define TFR_CFG_SVH

// core clock
`define TFR_CLK_MHZ 10

// register offsets on the access port
`define TFR_OFS_SENSE 8'h02
`define TFR_OFS_POWER 8'h27
`define TFR_OFS_RES_HI 8'h28
`define TFR_OFS_RES_LO 8'h29

// reset values: all three channels on, FIR code 0, inner elements
`define TFR_SENSE_RESET 32'h000001C0
`define TFR_POWER_RESET 7'h00

// field positions
`define TFR_F_MODE 1:0
`define TFR_F_INACT 6:4
`define TFR_F_POWER 6:0
`define TFR_F_BW 23:21
`define TFR_F_HALL 20:19
`define TFR_F_CHEN 8:6
`define TFR_HALL_INNER 2'h0
`define TFR_HALL_SUMMED 2'h2

// timing, in microseconds as printed; then a duty-cycle count and a timer limit in clock cycles
`define TFR_TEMP_PERIOD_US 8000
`define TFR_POD_US 8000
`define TFR_INACT_BASE_US 500
`define TFR_TEMP_EVERY 4'hA
`define TFR_TIMER_MAX 24'hFFFFFF

// inactive time in multiples of 0.5 ms, index = code (code 7 at top)
`define TFR_INACT_MULT {11'd2000, 11'd1000, 11'd200, 11'd100, \
    11'd20, 11'd10, 11'd2, 11'd1}

// update period in us per bandwidth code, {3 ch, 2 ch, 1 ch}
`define TFR_UPD_US_BW0 {10'd495, 10'd330, 10'd160}
`define TFR_UPD_US_BW1 {10'd255, 10'd170, 10'd80}
`define TFR_UPD_US_BW2 {10'd135, 10'd90, 10'd40}
`define TFR_UPD_US_BW4 {10'd207, 10'd138, 10'd64}
`define TFR_UPD_US_BW5 {10'd111, 10'd74, 10'd32}
`define TFR_UPD_US_BW6 {10'd63, 10'd42, 10'd16}

`endif

// ---- inc/tfr_pkg.sv ----
package tfr_pkg;

    typedef enum logic [1:0] {
        MODE_ACTIVE = 2'h0,
        MODE_SLEEP = 2'h1,
        MODE_DUTY = 2'h2,
        MODE_RSVD = 2'h3
    } tfr_mode_type;

    // gray order: wake -> measure -> inactive -> sleep
    typedef enum logic [1:0] {
        ST_WAKE = 2'h0,
        ST_MEASURE = 2'h1,
        ST_INACTIVE = 2'h3,
        ST_SLEEP = 2'h2
    } tfr_state_type;

    typedef struct packed {
        logic signed [11:0] x_inner;
        logic signed [11:0] y_inner;
        logic signed [11:0] z_inner;
        logic signed [11:0] x_east;
        logic signed [11:0] x_west;
        logic signed [11:0] y_north;
        logic signed [11:0] y_south;
        logic [11:0] temp;
    } tfr_elems_type;

    typedef struct packed {
        logic signed [11:0] x;
        logic signed [11:0] y;
        logic signed [11:0] z;
    } tfr_axes_type;

    typedef struct packed {
        tfr_state_type state;
        logic [23:0] timer;
        logic [23:0] temp_timer;
        logic [3:0] duty_cnt;
        logic [31:0] sense_cfg;
        logic [6:0] power;
        tfr_axes_type axes;
        logic [11:0] temp;
        logic [1:0] hall_stat;
        logic new_flag;
        logic int_flag;
        logic [31:0] lo_snap;
        logic snap_valid;
        logic [31:0] rdata;
    } tfr_top_state_type;

endpackage : tfr_pkg

// ---- tb/testbench.sv ----
`timescale 1ns/100ps

module testbench;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } tfr_row_type;

    logic core_clk;
    logic rst;
    logic [7:0] acc_addr;
    logic acc_wr;
    logic acc_rd;
    logic [31:0] acc_wdata;
    logic [31:0] acc_rdata;
    tfr_pkg::tfr_elems_type elems;
    tfr_pkg::tfr_axes_type int_threshold;
    logic [2:0] int_axis_en;
    logic int_event;
    logic [31:0] hi;
    logic [31:0] lo;
    logic [31:0] v;
    int failures;
    int n_checks;
    tfr_row_type rows [14] = '{
        '{8'h27, 32'hFFFFFF8C, 32'h0C}, '{8'h27, 32'h70, 32'h70},
        '{8'h27, 32'h60, 32'h60}, '{8'h27, 32'h50, 32'h50},
        '{8'h27, 32'h40, 32'h40}, '{8'h27, 32'h30, 32'h30},
        '{8'h27, 32'h20, 32'h20}, '{8'h27, 32'h10, 32'h10},
        '{8'h27, 32'h00, 32'h00}, '{8'h02, 32'hA5A5A5A5, 32'hA5A5A5A5},
        '{8'h02, 32'h006001C0, 32'h006001C0}, '{8'h10, 32'hFFFFFFFF, 32'h0},
        '{8'h02, 32'h00E001C0, 32'h00E001C0}, '{8'h02, 32'h00C001C0, 32'h00C001C0}
    };

    tfr_readout_top #(
        .TEMP_CYCLES(200), .POD_CYCLES(100), .INACT_BASE_CYCLES(5)
    ) dut_u (
        .core_clk(core_clk), .rst(rst), .acc_addr(acc_addr), .acc_wr(acc_wr),
        .acc_rd(acc_rd), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .elems(elems), .int_threshold(int_threshold),
        .int_axis_en(int_axis_en), .int_event(int_event)
    );

    tfr_host_model host_u (
        .core_clk(core_clk), .acc_addr(acc_addr), .acc_wr(acc_wr),
        .acc_rd(acc_rd), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // polls with paired reads; each poll clears the fresh flag
    task automatic wait_new();
        // a stale flag from an earlier read must not end the wait early
        hi = 32'h0;
        for (int i = 0; i < 150 && hi[7] !== 1'b1; i++) begin
            repeat (50) @(posedge core_clk);
            host_u.rd_result(hi, lo);
        end
        chk({31'h0, hi[7]}, 32'h1);
    endtask : wait_new

    task automatic wait_temp(input logic [5:0] t);
        for (int i = 0; i < 200 && lo[5:0] !== t; i++) begin
            repeat (100) @(posedge core_clk);
            host_u.rd(8'h29, lo);
        end
        chk({26'h0, lo[5:0]}, {26'h0, t});
    endtask : wait_temp

    task automatic int_case(input logic [11:0] tx, input logic [2:0] en,
        input logic e);
        int_threshold.x = tx;
        int_axis_en = en;
        repeat (3) @(posedge core_clk);
        #1;
        chk({31'h0, int_event}, {31'h0, e});
    endtask : int_case

    initial begin
        core_clk = 1'b0;
        forever begin
            #50 core_clk = ~core_clk;
        end
    end

    // the whole sequence needs about 17000 cycles
    initial begin
        #(100000 * 100);
        failures = failures + 1;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        elems = '0;
        elems.x_inner = 12'hC06;
        elems.y_inner = 12'h123;
        elems.z_inner = 12'h7FF;
        elems.temp = 12'hABC;
        int_threshold = '{12'h0, 12'h7FF, 12'h7FF};
        int_axis_en = 3'h0;
        hi = 32'h0;
        lo = 32'h0;
        failures = 0;
        n_checks = 0;
        repeat (20) @(posedge core_clk);
        #1;
        rst = 1'b0;
        host_u.rd(8'h02, v);
        chk(v, 32'h000001C0);
        host_u.rd(8'h27, v);
        chk(v, 32'h0);
        foreach (rows[i]) begin
            host_u.wr(rows[i].a, rows[i].d);
            host_u.rd(rows[i].a, v);
            chk(v, rows[i].e);
        end
        wait_new();
        chk(hi, 32'hC0127FAA);
        chk(lo, 32'h00063F3C);
        chk({{20{hi[31]}}, hi[31:24], lo[19:16]}, 32'hFFFFFC06);
        host_u.rd(8'h28, v);
        chk({31'h0, v[7]}, 32'h0);
        elems.x_inner = 12'h055;
        elems.temp = 12'h123;
        repeat (700) @(posedge core_clk);
        host_u.rd(8'h29, lo);
        chk({28'h0, lo[19:16]}, 32'h6);
        host_u.rd(8'h29, lo);
        chk({28'h0, lo[19:16]}, 32'h5);
        chk({26'h0, lo[5:0]}, 32'h23);
        int_case(12'h055, 3'h1, 1'b1);
        host_u.rd(8'h28, v);
        chk({31'h0, v[6]}, 32'h1);
        int_case(12'h056, 3'h1, 1'b0);
        int_case(12'hFFF, 3'h2, 1'b0);
        int_case(12'hFFF, 3'h3, 1'b1);
        int_case(12'hFFF, 3'h0, 1'b0);
        elems.x_east = 12'h064;
        elems.x_west = 12'hFE2;
        elems.y_north = 12'h200;
        elems.y_south = 12'h100;
        host_u.wr(8'h02, 32'h00D001C0);
        host_u.rd_result(hi, lo);
        wait_new();
        chk({8'h0, hi[31:8]}, 32'h0004307F);
        chk({18'h0, lo[19:6]}, 32'h0000183E);
        // back to the trimmed inner scheme
        host_u.wr(8'h02, 32'h00C001C0);
        host_u.wr(8'h27, 32'h1);
        host_u.rd(8'h28, v);
        elems.z_inner = 12'h001;
        elems.temp = 12'h456;
        repeat (1500) @(posedge core_clk);
        host_u.rd_result(hi, lo);
        chk({17'h0, hi[15:7], lo[5:0]}, {17'h0, 8'h7F, 1'b0, 6'h23});
        host_u.wr(8'h27, 32'h0);
        repeat (680) @(posedge core_clk);
        host_u.rd(8'h28, v);
        chk({31'h0, v[7]}, 32'h0);
        wait_new();
        chk({12'h0, hi[15:8], hi[5:0], lo[5:0]}, 32'h00000456);
        host_u.wr(8'h27, 32'h2);
        host_u.rd_result(hi, lo);
        wait_new();
        elems.temp = 12'h789;
        wait_temp(6'h09);
        elems.temp = 12'hFC0;
        repeat (2000) @(posedge core_clk);
        host_u.rd(8'h29, lo);
        chk({26'h0, lo[5:0]}, 32'h09);
        wait_temp(6'h00);
        // reset in mid-run brings the configuration back
        rst = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        rst = 1'b0;
        host_u.rd(8'h27, v);
        chk(v, 32'h0);
        host_u.rd(8'h02, v);
        chk(v, 32'h000001C0);
        finish_test();
    end
endmodule : testbench

// ---- tb/tfr_host_model.sv ----
`timescale 1ns/100ps

module tfr_host_model (
    // clock
    input wire logic core_clk,
    // register access port
    output logic [7:0] acc_addr,
    output logic acc_wr,
    output logic acc_rd,
    output logic [31:0] acc_wdata,
    input wire logic [31:0] acc_rdata
);
    initial begin
        acc_addr = 8'h00;
        acc_wr = 1'b0;
        acc_rd = 1'b0;
        acc_wdata = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        #1;
        acc_addr = a;
        acc_wdata = d;
        acc_wr = 1'b1;
        @(posedge core_clk);
        #1;
        acc_wr = 1'b0;
        // stale data is inverted so a late capture cannot pass by luck
        acc_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        #1;
        acc_addr = a;
        acc_rd = 1'b1;
        @(posedge core_clk);
        #1;
        acc_rd = 1'b0;
        d = acc_rdata;
    endtask : rd

    // both words back to back, strobe held, so they pair up
    task automatic rd_result(output logic [31:0] hi, output logic [31:0] lo);
        @(posedge core_clk);
        #1;
        acc_addr = 8'h28;
        acc_rd = 1'b1;
        @(posedge core_clk);
        #1;
        acc_addr = 8'h29;
        hi = acc_rdata;
        @(posedge core_clk);
        #1;
        acc_rd = 1'b0;
        lo = acc_rdata;
    endtask : rd_result
endmodule : tfr_host_model

// ---- tb/tfr_readout_checker.sv ----
`timescale 1ns/100ps

module tfr_readout_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register access port
    input wire logic [7:0] acc_addr,
    input wire logic acc_wr,
    input wire logic acc_rd,
    input wire logic [31:0] acc_wdata,
    input wire logic [31:0] acc_rdata,
    // threshold compare
    input wire logic [2:0] int_axis_en,
    input wire logic int_event
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    rdata_hold_a: assert property (!acc_rd |=> $stable(acc_rdata))
        else $error("read data moved without a read");
    power_readback_a: assert property (
        acc_wr && acc_addr == 8'h27 ##1 !acc_wr ##1 acc_rd && acc_addr == 8'h27
        |=> acc_rdata == {25'h0, $past(acc_wdata[6:0], 3)})
        else $error("power word readback wrong");
    power_upper_a: assert property (
        acc_rd && acc_addr == 8'h27 |=> acc_rdata[31:7] == 25'h0)
        else $error("power word upper bits not zero");
    sense_readback_a: assert property (
        acc_wr && acc_addr == 8'h02 ##1 !acc_wr ##1 acc_rd && acc_addr == 8'h02
        |=> acc_rdata == $past(acc_wdata, 3))
        else $error("sensing word readback wrong");
    lo_reserved_a: assert property (
        acc_rd && acc_addr == 8'h29 |=> acc_rdata[31:20] == 12'h0)
        else $error("lower word reserved bits set");
    hall_status_a: assert property (
        acc_rd && acc_addr == 8'h29 |=> !acc_rdata[6])
        else $error("scheme status not inner or summed");
    int_bit_a: assert property (
        acc_rd && acc_addr == 8'h28 |=> acc_rdata[6] == $past(int_event))
        else $error("upper word event bit differs from pin");
    int_off_a: assert property (int_axis_en == 3'h0 |=> !int_event)
        else $error("event with all axes disabled");

    cover property (acc_rd && acc_addr == 8'h28 ##1 acc_rd && acc_addr == 8'h29);
    cover property ($rose(int_event));
    cover property (acc_wr && acc_addr == 8'h27 && acc_wdata[1:0] == 2'h2);
endmodule : tfr_readout_checker

bind tfr_readout_top tfr_readout_checker chk_u (
    .core_clk(core_clk), .rst(rst), .acc_addr(acc_addr), .acc_wr(acc_wr),
    .acc_rd(acc_rd), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .int_axis_en(int_axis_en), .int_event(int_event)
);
